// ===== bench/rlc_ra_channel_model.sv
// Far-side model: superframe timing, slotted opportunities and control slots
`timescale 1ns/100ps
module rlc_ra_channel_model
  import rlc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic misorder,
  output logic superframe_start,
  output logic [NCH-1:0] block_start,
  output logic [NCH-1:0] slot_valid,
  output rlc_pos_t [NCH-1:0] slot_pos,
  output logic ctrl_slot
);
  logic [3:0] cnt_r;
  logic [15:0] sf_r;
  logic slot_now;
  // One superframe is 16 cycles; block_start splits it into two blocks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 4'h0;
    end else if (run) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      cnt_r <= 4'h0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sf_r <= 16'h0000;
    end else if (run && cnt_r == 4'hF) begin
      sf_r <= sf_r + 16'h0001;
    end
  end
  assign slot_now = run && cnt_r != 4'h0 && cnt_r[1:0] == 2'b00;
  assign superframe_start = run && cnt_r == 4'h0;
  assign block_start = {NCH{run && cnt_r[2:0] == 3'h0}};
  assign slot_valid = {NCH{slot_now}};
  assign ctrl_slot = run && cnt_r[1:0] == 2'b10;
  // Off-slot position changes every cycle while running so a stale value never looks live
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (slot_now) begin
        slot_pos[i] = {sf_r, 12'h000, misorder ? 4'hF - cnt_r : cnt_r};
      end else begin
        slot_pos[i] = {~sf_r, 12'hFFF, ~cnt_r};
      end
    end
  end
endmodule

// ===== bench/rlc_ra_load_control_tb.sv
// Testbench: register access, gating, caps, ordering and control slot selection
`timescale 1ns/100ps
module rlc_ra_load_control_tb
  import rlc_pkg::*;
;
  logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run, misorder;
  logic superframe_start, ctrl_request, ctrl_slot, ctrl_go;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [NCH-1:0] block_start, new_data, buf_pending, slot_valid, tx_go;
  rlc_pos_t [NCH-1:0] slot_pos;
  logic [NCH-1:0][7:0] tx_payloads;
  int failures, total_checks, ngo, nslot, go_slot;
  int gcnt[8];
  logic [7:0] pl[8];

  rlc_ra_load_control u_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .superframe_start(superframe_start), .block_start(block_start), .new_data(new_data),
    .buf_pending(buf_pending), .slot_valid(slot_valid), .slot_pos(slot_pos), .tx_go(tx_go),
    .tx_payloads(tx_payloads), .ctrl_request(ctrl_request), .ctrl_slot(ctrl_slot), .ctrl_go(ctrl_go));
  rlc_ra_channel_model u_far (.clk(clk), .reset_n(reset_n), .run(run), .misorder(misorder),
    .superframe_start(superframe_start), .block_start(block_start), .slot_valid(slot_valid),
    .slot_pos(slot_pos), .ctrl_slot(ctrl_slot));

  always #12.5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20) begin
      failures++;
      report_and_stop();
    end
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    wb(1'b0, adr, 32'h0000_0000);
    check(what, exp, rd);
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    run <= 1'b0;
    misorder <= 1'b0;
    buf_pending <= 2'h0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  // Static parameters, idle floor and control word for channel 0
  task automatic setup(input logic [31:0] par, input logic [7:0] ctrl);
    wb(1'b1, {3'h0, OFF_STAT_PAR}, par);
    wb(1'b1, {3'h0, OFF_STAT_IDLE}, 32'h0000_0002);
    wb(1'b1, {3'h0, OFF_CTRL}, {24'h0, ctrl});
  endtask

  // Runs whole superframes with channel 0 holding data, tallying grants per superframe
  task automatic run_sf(input int nb);
    for (int i = 0; i < 8; i++) begin
      gcnt[i] = 0;
      pl[i] = 8'h00;
    end
    ngo = 0;
    nslot = 0;
    go_slot = 0;
    @(posedge clk);
    new_data <= 2'h1;
    buf_pending <= 2'h1;
    @(posedge clk);
    new_data <= 2'h0;
    run <= 1'b1;
    for (int k = 0; k < nb * 16; k++) begin
      @(negedge clk);
      if (ctrl_slot === 1'b1) nslot++;
      if (ctrl_go === 1'b1) begin
        ngo++;
        go_slot = nslot;
      end
      if (tx_go[0] === 1'b1) begin
        gcnt[k / 16]++;
        pl[k / 16] = tx_payloads[0];
      end
      if (tx_go[1] === 1'b1) gcnt[7]++;
    end
    @(posedge clk);
    run <= 1'b0;
  endtask

  task automatic t_regs();
    do_reset();
    rd_chk({3'h0, OFF_CTRL}, 32'h0000_0000, "ctrl reset");
    rd_chk({3'h0, OFF_STAT_PAR}, PAR_RST, "static params reset");
    rd_chk(CH_STRIDE + {3'h0, OFF_DYN_PAR}, PAR_RST, "ch1 dynamic params reset");
    rd_chk(OFF_CTRL_WIN, {24'h0, WIN_RST}, "window reset");
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rd_chk(8'hFC, 32'h0000_0000, "unmapped read");
    wb(1'b1, {3'h0, OFF_STAT_IDLE}, 32'h0000_00A5);
    rd_chk({3'h0, OFF_STAT_IDLE}, 32'h0000_00A5, "idle floor rw");
  endtask

  task automatic t_scheme0();
    do_reset();
    run_sf(2);
    check("grants block0", 3, gcnt[0]);
    check("grants block1", 3, gcnt[1]);
    check("slotted payloads", 1, pl[0]);
    check("ch1 grants", 0, gcnt[7]);
    wb(1'b1, {3'h0, OFF_CTRL}, 32'h0000_0040);
    run_sf(1);
    check("block_start split", 2, gcnt[0]);
  endtask

  task automatic t_caps();
    do_reset();
    setup(32'h0102_0000, 8'h01);
    run_sf(3);
    check("capped block0", 2, gcnt[0]);
    check("idle block1", 0, gcnt[1]);
    check("idle block2", 0, gcnt[2]);
    wb(1'b1, {3'h0, OFF_STAT_IDLE}, 32'h0000_0000);
    run_sf(3);
    check("zero floor block0", 2, gcnt[0]);
    check("consec cap block1", 0, gcnt[1]);
    check("silent block clears", 2, gcnt[2]);
  endtask

  // Back-off armed before the run, then probability dropped so only back-off gates
  task automatic t_backoff();
    do_reset();
    setup(32'h0402_FF02, 8'h01);
    @(posedge clk);
    new_data <= 2'h1;
    // Two draws in a row can never both hit the top value
    repeat (2) @(posedge clk);
    new_data <= 2'h0;
    wb(1'b1, {3'h0, OFF_STAT_PAR}, 32'h0402_0002);
    rd_chk({3'h0, OFF_STATUS}, 32'h0200_0000, "back-off armed");
    run_sf(3);
    check("back-off block0", 0, gcnt[0]);
    check("after back-off block1", 2, gcnt[1]);
  endtask

  task automatic t_dyn();
    do_reset();
    setup(32'h0102_0000, 8'h21);
    wb(1'b1, {3'h0, OFF_DYN_PAR}, 32'hFF01_FFFF);
    wb(1'b1, {3'h0, OFF_DYN_IDLE}, 32'h0000_00FF);
    run_sf(2);
    check("dynamic cap block0", 1, gcnt[0]);
    check("default idle block1", 0, gcnt[1]);
  endtask

  task automatic t_repl();
    do_reset();
    setup(32'h0402_0000, 8'h11);
    run_sf(3);
    for (int b = 0; b < 3; b++) begin
      check("replicated grants", 1, gcnt[b]);
      check("replicated payloads", 2, pl[b]);
    end
  endtask

  task automatic t_order();
    do_reset();
    misorder <= 1'b1;
    run_sf(2);
    check("descending slots block0", 1, gcnt[0]);
    wb(1'b0, {3'h0, OFF_FLAGS}, 32'h0000_0000);
    check("order flag set", 1, rd[FLG_ORDER_BIT]);
    wb(1'b1, {3'h0, OFF_FLAGS}, 32'h0000_0001);
    wb(1'b0, {3'h0, OFF_FLAGS}, 32'h0000_0000);
    check("order flag cleared", 0, rd[FLG_ORDER_BIT]);
  endtask

  task automatic t_ctrl();
    do_reset();
    wb(1'b1, OFF_CTRL_WIN, 32'h0000_0003);
    @(posedge clk);
    ctrl_request <= 1'b1;
    @(posedge clk);
    ctrl_request <= 1'b0;
    run_sf(2);
    check("control grants", 1, ngo);
    check("control slot in window", 1, go_slot >= 1 && go_slot <= 3);
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    run = 1'b0;
    misorder = 1'b0;
    ctrl_request = 1'b0;
    new_data = 2'h0;
    buf_pending = 2'h0;
    failures = 0;
    total_checks = 0;
    t_regs();
    t_scheme0();
    t_caps();
    t_backoff();
    t_dyn();
    t_repl();
    t_order();
    t_ctrl();
    report_and_stop();
  end
endmodule

// ===== design/rlc_pkg.sv
// Package: register map, field layout and types for the random access load control block
package rlc_pkg;
  localparam int NCH = 2;
  localparam int ADR_W = 8;
  // Per channel register window, 0x20 bytes each
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT_PAR = 5'h04;
  localparam logic [4:0] OFF_STAT_IDLE = 5'h08;
  localparam logic [4:0] OFF_DYN_PAR = 5'h0C;
  localparam logic [4:0] OFF_DYN_IDLE = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;
  localparam logic [4:0] OFF_FLAGS = 5'h18;
  localparam logic [7:0] OFF_CTRL_WIN = 8'h40;
  // Control register fields
  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_SCHEME_W = 4;
  localparam int CTRL_CRDSA_BIT = 4;
  localparam int CTRL_DYN_BIT = 5;
  localparam int CTRL_BLK_BIT = 6;
  localparam int CTRL_W = 7;
  // Flags register fields
  localparam int FLG_ORDER_BIT = 0;
  localparam int FLG_INBLK_BIT = 1;
  // Dynamic field value meaning "use the static default"
  localparam logic [7:0] USE_DEFAULT = 8'hFF;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [31:0] PAR_RST = 32'h0101_0000;
  localparam logic [7:0] IDLE_RST = 8'h00;
  localparam logic [7:0] WIN_RST = 8'h01;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  typedef struct packed {
    logic [7:0] max_consec;
    logic [7:0] max_payload;
    logic [7:0] probability;
    logic [7:0] back_off;
  } rlc_par_t;

  typedef struct packed {
    logic [15:0] superframe_sequence;
    logic [15:0] timeslot;
  } rlc_pos_t;

  typedef enum logic [0:0] {CS_IDLE, CS_WAIT} rlc_cstate_t;
endpackage

// ===== design/rlc_ra_load_control.sv
// Random access load control: per channel gating of traffic and control slot selection
// Summary of operation
// - Control slot is picked uniformly among slots within the randomisation window.
// - Scheme code zero: every opportunity is used while data is pending.
// - Nonzero scheme applies load control, dynamic when enabled, else stationary.
// - Blocks per channel; unconfigured channel uses superframe as its one block.
// - Stationary control uses the static parameter registers.
// - Dynamic control takes the dynamic parameter registers instead.
// - Reserved dynamic code selects the static default for that field.
// - Same gating logic for static and dynamic; only parameter source differs.
// - Each channel has its own independent load control state.
// - New data defers access by back-off blocks with back-off probability.
// - After back-off, each opportunity is used with one minus probability.
// - Replicated-burst: block is the opportunity, payloads sent as repeats.
// - Replicated-burst positive decision transmits payloads within that block.
// - Slotted: each slot not on a block start cycle is one opportunity carrying exactly one payload.
// - Slotted opportunities within a block taken in ascending superframe then timeslot order.
// - Under load control, payloads per block never exceed the per-block cap.
// - Under load control, consecutive transmitting blocks never exceed the consecutive cap.
// - After the consecutive cap, stay silent for the idle block floor, or for one block if the floor is zero.
`timescale 1ns/100ps
module rlc_ra_load_control
  import rlc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic superframe_start,
  input wire logic [NCH-1:0] block_start,
  input wire logic [NCH-1:0] new_data,
  input wire logic [NCH-1:0] buf_pending,
  input wire logic [NCH-1:0] slot_valid,
  input wire rlc_pos_t [NCH-1:0] slot_pos,
  output logic [NCH-1:0] tx_go,
  output logic [NCH-1:0][7:0] tx_payloads,
  input wire logic ctrl_request,
  input wire logic ctrl_slot,
  output logic ctrl_go
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ LFSR_TAPS) : (s >> 1);
  endfunction

  // Bus: ack one cycle after the request, write lands on the edge the master sees ack
  logic ack_r;
  logic wr_en;
  logic [31:0] rd_nxt;
  logic [31:0] rd_r;
  logic [NCH-1:0][6:0][31:0] ch_rd;
  logic [7:0] win_r;

  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == OFF_CTRL_WIN) begin
      rd_nxt = {24'h00_0000, win_r};
    end
    for (int c = 0; c < NCH; c++) begin
      if (wb_adr_i[7:5] == 3'(c) && wb_adr_i[4:2] != 3'h7 && wb_adr_i[1:0] == 2'h0) begin
        rd_nxt = ch_rd[c][wb_adr_i[4:2]];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_r <= 32'h0000_0000;
    end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_r <= WIN_RST;
    end else if (wr_en && wb_adr_i == OFF_CTRL_WIN && wb_sel_i[0]) begin
      win_r <= wb_dat_i[7:0];
    end
  end

  // Control slot selection
  rlc_cstate_t cst_r;
  logic [15:0] clfsr_r;
  logic [7:0] target_r;
  logic [7:0] seen_r;
  logic ctrl_go_r;
  logic [15:0] pick;

  assign ctrl_go = ctrl_go_r;
  // Scaling by the window keeps the draw uniform without a divider
  assign pick = clfsr_r[15:8] * win_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clfsr_r <= LFSR_SEED;
    end else begin
      clfsr_r <= lfsr_step(clfsr_r);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cst_r <= CS_IDLE;
      target_r <= 8'h00;
      seen_r <= 8'h00;
      ctrl_go_r <= 1'b0;
    end else begin
      ctrl_go_r <= 1'b0;
      case (cst_r)
        CS_IDLE: begin
          if (ctrl_request && win_r != 8'h00) begin
            target_r <= pick[15:8];
            seen_r <= 8'h00;
            cst_r <= CS_WAIT;
          end
        end
        CS_WAIT: begin
          if (ctrl_slot) begin
            seen_r <= seen_r + 8'h01;
            if (seen_r == target_r) begin
              ctrl_go_r <= 1'b1;
              cst_r <= CS_IDLE;
            end
          end
        end
        default: begin
          cst_r <= CS_IDLE;
        end
      endcase
    end
  end

  ctrl_window_a: assert property (ctrl_go |-> seen_r <= win_r && $past(ctrl_slot))
    else $error("control slot outside randomisation window");

  // One independent instance per channel
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [CTRL_W-1:0] ctrl_r;
    rlc_par_t spar_r;
    rlc_par_t dpar_r;
    rlc_par_t par;
    logic [7:0] sidle_r;
    logic [7:0] didle_r;
    logic [7:0] idle_min;
    logic [15:0] lfsr_r;
    logic [7:0] backoff_r;
    logic [7:0] pay_r;
    logic [7:0] consec_r;
    logic [7:0] idle_r;
    logic inblk_r;
    logic order_err_r;
    logic crdsa_opp_r;
    logic last_v_r;
    rlc_pos_t last_r;
    logic go_r;
    logic [7:0] npay_r;
    logic blk;
    logic lc_on;
    logic crdsa;
    logic sel_hit;
    logic ordered;
    logic sa_opp;
    logic opp;
    logic pass;
    logic go;
    logic [4:0] off;
    logic [7:0] rnd;

    assign off = wb_adr_i[4:0];
    assign sel_hit = wr_en && wb_adr_i[7:5] == 3'(i);
    assign lc_on = ctrl_r[CTRL_SCHEME_LSB +: CTRL_SCHEME_W] != 4'h0;
    assign crdsa = ctrl_r[CTRL_CRDSA_BIT];
    assign blk = ctrl_r[CTRL_BLK_BIT] ? block_start[i] : superframe_start;
    assign rnd = lfsr_r[15:8];

    // Field-wise source select; gating below never looks at the source
    always_comb begin
      par = spar_r;
      idle_min = sidle_r;
      if (ctrl_r[CTRL_DYN_BIT]) begin
        par.back_off = dpar_r.back_off == USE_DEFAULT ? spar_r.back_off : dpar_r.back_off;
        par.probability = dpar_r.probability == USE_DEFAULT ? spar_r.probability : dpar_r.probability;
        par.max_payload = dpar_r.max_payload == USE_DEFAULT ? spar_r.max_payload : dpar_r.max_payload;
        par.max_consec = dpar_r.max_consec == USE_DEFAULT ? spar_r.max_consec : dpar_r.max_consec;
        idle_min = didle_r == USE_DEFAULT ? sidle_r : didle_r;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        ctrl_r <= CTRL_RST;
        spar_r <= PAR_RST;
        dpar_r <= PAR_RST;
        sidle_r <= IDLE_RST;
        didle_r <= IDLE_RST;
      end else if (sel_hit) begin
        case (off)
          OFF_CTRL: ctrl_r <= CTRL_W'(merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
          OFF_STAT_PAR: spar_r <= merge(spar_r, wb_dat_i, wb_sel_i);
          OFF_DYN_PAR: dpar_r <= merge(dpar_r, wb_dat_i, wb_sel_i);
          OFF_STAT_IDLE: sidle_r <= wb_sel_i[0] ? wb_dat_i[7:0] : sidle_r;
          OFF_DYN_IDLE: didle_r <= wb_sel_i[0] ? wb_dat_i[7:0] : didle_r;
          default: begin
          end
        endcase
      end
    end

    assign ch_rd[i][0] = {25'h000_0000, ctrl_r};
    assign ch_rd[i][1] = spar_r;
    assign ch_rd[i][2] = {24'h00_0000, sidle_r};
    assign ch_rd[i][3] = dpar_r;
    assign ch_rd[i][4] = {24'h00_0000, didle_r};
    assign ch_rd[i][5] = {backoff_r, idle_r, consec_r, pay_r};
    assign ch_rd[i][6] = {30'h0000_0000, inblk_r, order_err_r};

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        lfsr_r <= LFSR_SEED ^ 16'(i + 1);
      end else begin
        lfsr_r <= lfsr_step(lfsr_r);
      end
    end

    // Opportunity: slot on slotted channels, block start one cycle late on replicated ones
    assign ordered = !last_v_r || slot_pos[i] > last_r;
    assign sa_opp = !crdsa && slot_valid[i] && !blk && ordered;
    assign opp = crdsa ? crdsa_opp_r : sa_opp;
    assign pass = !lc_on || (backoff_r == 8'h00 && idle_r == 8'h00 && rnd >= par.probability &&
                  consec_r < par.max_consec);
    assign go = opp && buf_pending[i] && pass && (crdsa ? (!lc_on || pay_r == 8'h00) :
                (!lc_on || pay_r < par.max_payload)) && (!lc_on || par.max_payload != 8'h00);

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        crdsa_opp_r <= 1'b0;
        last_v_r <= 1'b0;
        last_r <= '0;
        order_err_r <= 1'b0;
      end else begin
        crdsa_opp_r <= crdsa && blk;
        if (blk) begin
          last_v_r <= 1'b0;
        end else if (!crdsa && slot_valid[i] && ordered) begin
          last_v_r <= 1'b1;
          last_r <= slot_pos[i];
        end
        // Set wins over a same-cycle write-one-to-clear
        if (!crdsa && slot_valid[i] && !ordered) begin
          order_err_r <= 1'b1;
        end else if (sel_hit && off == OFF_FLAGS && wb_sel_i[0] && wb_dat_i[FLG_ORDER_BIT]) begin
          order_err_r <= 1'b0;
        end
      end
    end

    // Back-off on arrival of new data, counted in blocks
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        backoff_r <= 8'h00;
      end else if (new_data[i] && lc_on && rnd < par.probability) begin
        backoff_r <= par.back_off;
      end else if (blk && backoff_r != 8'h00) begin
        backoff_r <= backoff_r - 8'h01;
      end
    end

    // Block accounting
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        pay_r <= 8'h00;
        consec_r <= 8'h00;
        idle_r <= 8'h00;
        inblk_r <= 1'b0;
      end else if (blk) begin
        pay_r <= 8'h00;
        inblk_r <= 1'b0;
        if (inblk_r) begin
          // Parking at the cap keeps the next block silent even with a zero idle floor
          if (consec_r < par.max_consec) begin
            consec_r <= consec_r + 8'h01;
          end
          if (consec_r + 8'h01 >= par.max_consec) begin
            idle_r <= idle_min;
          end
        end else begin
          consec_r <= 8'h00;
          if (idle_r != 8'h00) begin
            idle_r <= idle_r - 8'h01;
          end
        end
      end else if (go) begin
        inblk_r <= 1'b1;
        pay_r <= crdsa ? par.max_payload : pay_r + 8'h01;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        go_r <= 1'b0;
        npay_r <= 8'h00;
      end else begin
        go_r <= go;
        npay_r <= crdsa ? par.max_payload : 8'h01;
      end
    end

    assign tx_go[i] = go_r;
    assign tx_payloads[i] = go_r ? npay_r : 8'h00;

    no_control_a: assert property (sa_opp && buf_pending[i] && !lc_on |=> tx_go[i])
      else $error("uncontrolled channel skipped an opportunity");
    payload_cap_a: assert property (lc_on && !blk |-> pay_r <= par.max_payload)
      else $error("payload count above per-block cap");
    consec_cap_a: assert property (lc_on && $stable(par.max_consec) |-> consec_r <= par.max_consec)
      else $error("consecutive block count above cap");
    idle_hold_a: assert property (lc_on && idle_r != 8'h00 |=> !tx_go[i])
      else $error("transmission during idle blocks");
    back_off_a: assert property (lc_on && backoff_r != 8'h00 |=> !tx_go[i])
      else $error("transmission during back-off");
    slot_single_a: assert property (tx_go[i] && !$past(crdsa) |-> tx_payloads[i] == 8'h01)
      else $error("slotted grant not one payload");
    burst_block_a: assert property (tx_go[i] && $past(crdsa) |-> $past(blk, 2))
      else $error("replicated grant not at block start");
    slot_order_a: assert property (tx_go[i] && !$past(crdsa) |-> $past(ordered) && $past(slot_valid[i]))
      else $error("slot granted out of order");
    consec_clear_a: assert property (blk && !inblk_r |=> consec_r == 8'h00)
      else $error("consecutive count kept after silent block");
  end

endmodule
